// ### hdl/misc_cfg_pkg.sv
// Constants, types and field layout of the system configuration register bank
//==========================================================================
// What this block does
// RULE1 - Crypto memory base is 7 bits, each unit one 1KB page, up to 127KB
// RULE2 - Crypto 2KB window wraps modulo 128KB; base 0x7F splits top and bottom
// RULE3 - Four-bit lamp current trim, bits 9 to 6, drives the driver trim
// RULE4 - Each lamp takes pulse channel or breathing source, passed only when on
// RULE5 - Fine count copy captured at sleep entry and restored at wake-up
// RULE6 - Software touches the copy only while radio sleeps; awake writes are inert
// RULE7 - Output divider bits 14 to 8, zero means one, resets to 0x1
// RULE8 - Loop divider bits 6 to 0, zero means one, resets to 0x6
// RULE9 - Regulator reference hold bit 2: 0 tracks, 1 holds sampled value
// RULE10 - VCO current bit 14: 0 manual setting, 1 calibration result
// RULE11 - Phase detector delay bits 13 to 12, reset code 2 (1.13 ns)
// RULE12 - Precharge released start delay times 48 ns after synth enable
// RULE13 - Synth enable and regulator enable are plain levels, reset to 0
// RULE14 - Reserved bits read zero and ignore writes
package misc_cfg_pkg;

    //==================================================================
    // Register offsets
    localparam logic [31:0] OFF_MEM_BASE = 32'h5000330a;
    localparam logic [31:0] OFF_LAMP = 32'h5000330c;
    localparam logic [31:0] OFF_FINE = 32'h5000330e;
    localparam logic [31:0] OFF_PLL1 = 32'h50003310;
    localparam logic [31:0] OFF_PLL2 = 32'h50003312;
    localparam logic [31:0] OFF_PLL3 = 32'h50003314;

    //==================================================================
    // Field positions
    localparam int TRIM_LSB = 6;
    localparam int ON_LSB = 3;
    localparam int SRC_LSB = 0;
    localparam int RDIV_LSB = 8;
    localparam int HOLD_BIT = 2;
    localparam int LDO_BIT = 1;
    localparam int PLL_EN_BIT = 0;
    localparam int VCO_BIT = 14;
    localparam int PDEL_LSB = 12;
    localparam int NDIV_LSB = 0;
    localparam int RECAL_BIT = 15;
    localparam int SDEL_LSB = 10;
    localparam int PAGE_BITS = 10;

    //==================================================================
    // Reset values
    localparam logic [6:0] RST_BASE = 7'h00;
    localparam logic [9:0] RST_LAMP = 10'h000;
    localparam logic [9:0] RST_FINE = 10'h000;
    localparam logic [6:0] RST_RDIV = 7'h01;
    localparam logic [6:0] RST_NDIV = 7'h06;
    localparam logic [1:0] RST_PDEL = 2'h2;
    localparam logic [4:0] RST_SDEL = 5'h0f;

    //==================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SDEL_LSB_NS = 48;
    localparam logic [10:0] CLK_STEP_NS = 11'(CLK_PERIOD_NS);
    localparam logic [5:0] SDEL_STEP_NS = 6'(SDEL_LSB_NS);

    //==================================================================
    // Types
    typedef enum logic [1:0] {
        PRE_IDLE = 2'b00,
        PRE_WAIT = 2'b01,
        PRE_DONE = 2'b10
    } pre_e;

    typedef struct packed {
        logic [3:0] trim;
        logic [2:0] lamp;
    } lamp_out_s;

    typedef struct packed {
        logic [6:0] out_div;
        logic [6:0] loop_div;
        logic ref_hold;
        logic reg_on;
        logic synth_on;
        logic vco_auto;
        logic [1:0] pd_delay;
        logic recal;
        logic precharge_off;
    } pll_ctrl_s;

    typedef struct packed {
        logic [6:0] base;
        logic [9:0] lamp;
        logic [9:0] fine;
        logic [6:0] rdiv;
        logic hold;
        logic ldo;
        logic pll_en;
        logic vco_auto;
        logic [1:0] pdel;
        logic [6:0] ndiv;
        logic recal;
        logic [4:0] sdel;
        pre_e pre;
        logic [10:0] ns;
        logic [15:0] rdata;
        logic [16:0] maddr;
        logic [2:0] lamps;
        logic [9:0] rest;
        logic load;
    } state_s;

endpackage : misc_cfg_pkg

// ### hdl/misc_system_config_regs.sv
// System configuration register bank: crypto page, lamps, fine count, synth
`timescale 1ns/1ps
module misc_system_config_regs (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [31:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Crypto engine window
    input wire logic [10:0] crypto_addr_i,
    output logic [16:0] mem_addr_o,
    // Lamp sources
    input wire logic pulse_channel_a_i,
    input wire logic pulse_channel_b_i,
    input wire logic pulse_channel_c_i,
    input wire logic breath_i,
    output misc_cfg_pkg::lamp_out_s lamp_o,
    // Radio fine counter
    input wire logic [9:0] radio_fine_counter_i,
    input wire logic radio_asleep_i,
    input wire logic sleep_entry_i,
    input wire logic wake_i,
    output logic [9:0] fine_restore_o,
    output logic fine_load_o,
    // Synthesizer controls
    output misc_cfg_pkg::pll_ctrl_s pll_o
);
    import misc_cfg_pkg::*;

    //==================================================================
    // Register selection codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_BASE = 3'h1;
    localparam logic [2:0] SEL_LAMP = 3'h2;
    localparam logic [2:0] SEL_FINE = 3'h3;
    localparam logic [2:0] SEL_PLL1 = 3'h4;
    localparam logic [2:0] SEL_PLL2 = 3'h5;
    localparam logic [2:0] SEL_PLL3 = 3'h6;

    // Address decode, shared by the write and read paths
    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        logic [2:0] s;
        s = SEL_NONE;
        case (a)
            OFF_MEM_BASE: s = SEL_BASE;
            OFF_LAMP: s = SEL_LAMP;
            OFF_FINE: s = SEL_FINE;
            OFF_PLL1: s = SEL_PLL1;
            OFF_PLL2: s = SEL_PLL2;
            OFF_PLL3: s = SEL_PLL3;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction : reg_sel

    // Zero divide codes behave as divide by one
    function automatic logic [6:0] eff_div(input logic [6:0] d);
        return (d == 7'h00) ? 7'h01 : d;
    endfunction : eff_div

    //==================================================================
    // State
    state_s cur_r;
    state_s cur_nxt;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic [10:0] target_ns;
    logic [2:0] src_pulse;
    logic [2:0] lamp_nxt;
    logic fine_wr_ok;

    assign wsel = wr_i ? reg_sel(addr_i) : SEL_NONE;
    assign rsel = reg_sel(addr_i);

    // Delay target in ns; 31 * 48 fits 11 bits
    assign target_ns = 11'(cur_r.sdel * SDEL_STEP_NS);

    // Awake writes are dropped so software only moves the copy while the radio sleeps
    assign fine_wr_ok = radio_asleep_i && !sleep_entry_i; // see RULE6

    //==================================================================
    // Lamp routing, one slice per lamp
    assign src_pulse = {pulse_channel_c_i, pulse_channel_b_i, pulse_channel_a_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_lamp
            // Source select picks pulse or breath; enable gates the result
            assign lamp_nxt[gi] = cur_r.lamp[ON_LSB + gi] &&
                (cur_r.lamp[SRC_LSB + gi] ? breath_i : src_pulse[gi]); // see RULE4
        end
    endgenerate

    //==================================================================
    // Next-state logic
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.load = 1'b0;

        // Register writes; reserved bits are simply not stored
        case (wsel)
            SEL_BASE: begin
                cur_nxt.base = wdata_i[6:0]; // see RULE1
            end
            SEL_LAMP: begin
                cur_nxt.lamp = wdata_i[9:0]; // see RULE14
            end
            SEL_FINE: begin
                if (fine_wr_ok) begin
                    cur_nxt.fine = wdata_i[9:0]; // see RULE6
                end
            end
            SEL_PLL1: begin
                cur_nxt.rdiv = wdata_i[RDIV_LSB +: 7]; // see RULE7
                cur_nxt.hold = wdata_i[HOLD_BIT]; // see RULE9
                cur_nxt.ldo = wdata_i[LDO_BIT]; // see RULE13
                cur_nxt.pll_en = wdata_i[PLL_EN_BIT]; // see RULE13
            end
            SEL_PLL2: begin
                cur_nxt.vco_auto = wdata_i[VCO_BIT]; // see RULE10
                cur_nxt.pdel = wdata_i[PDEL_LSB +: 2]; // see RULE11
                cur_nxt.ndiv = wdata_i[NDIV_LSB +: 7]; // see RULE8
            end
            SEL_PLL3: begin
                cur_nxt.recal = wdata_i[RECAL_BIT];
                cur_nxt.sdel = wdata_i[SDEL_LSB +: 5];
            end
            default: begin
                cur_nxt.load = 1'b0;
            end
        endcase

        // Hardware capture beats a software write in the same cycle
        if (sleep_entry_i) begin
            cur_nxt.fine = radio_fine_counter_i; // see RULE5
        end

        // Wake-up hands the saved value back as a one-cycle load
        cur_nxt.rest = cur_r.fine;
        cur_nxt.load = wake_i; // see RULE5

        // Read data, valid the cycle after the strobe only
        cur_nxt.rdata = 16'h0000;
        if (rd_i) begin
            case (rsel)
                SEL_BASE: cur_nxt.rdata = {9'h000, cur_r.base};
                SEL_LAMP: cur_nxt.rdata = {6'h00, cur_r.lamp};
                SEL_FINE: cur_nxt.rdata = {6'h00, cur_r.fine};
                SEL_PLL1: cur_nxt.rdata = {1'b0, cur_r.rdiv, 5'h00,
                    cur_r.hold, cur_r.ldo, cur_r.pll_en}; // see RULE14
                SEL_PLL2: cur_nxt.rdata = {1'b0, cur_r.vco_auto, cur_r.pdel,
                    5'h00, cur_r.ndiv};
                SEL_PLL3: cur_nxt.rdata = {cur_r.recal, cur_r.sdel, 10'h000};
                default: cur_nxt.rdata = 16'h0000;
            endcase
        end

        // Crypto window: page offset plus local address, wrapped at 128KB
        cur_nxt.maddr = 17'({cur_r.base, {PAGE_BITS{1'b0}}} +
            {6'h00, crypto_addr_i}); // see RULE2

        cur_nxt.lamps = lamp_nxt;

        // Precharge release timer, counted in ns so the delay rounds up
        case (cur_r.pre)
            PRE_IDLE: begin
                cur_nxt.ns = 11'h000;
                if (cur_r.pll_en) begin
                    cur_nxt.pre = PRE_WAIT;
                end
            end
            PRE_WAIT: begin
                if (!cur_r.pll_en) begin
                    cur_nxt.pre = PRE_IDLE;
                end else if (cur_r.ns >= target_ns) begin
                    cur_nxt.pre = PRE_DONE; // see RULE12
                end else begin
                    cur_nxt.ns = cur_r.ns + CLK_STEP_NS;
                end
            end
            PRE_DONE: begin
                if (!cur_r.pll_en) begin
                    cur_nxt.pre = PRE_IDLE;
                end
            end
            default: begin
                cur_nxt.pre = PRE_IDLE;
            end
        endcase
    end

    //==================================================================
    // State register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cur_r <= '0;
            cur_r.base <= RST_BASE;
            cur_r.lamp <= RST_LAMP;
            cur_r.fine <= RST_FINE;
            cur_r.rdiv <= RST_RDIV; // see RULE7
            cur_r.ndiv <= RST_NDIV; // see RULE8
            cur_r.pdel <= RST_PDEL; // see RULE11
            cur_r.sdel <= RST_SDEL;
            cur_r.pre <= PRE_IDLE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    //==================================================================
    // Outputs, all from the state register
    assign rdata_o = cur_r.rdata;
    assign mem_addr_o = cur_r.maddr;
    assign lamp_o.trim = cur_r.lamp[TRIM_LSB +: 4]; // see RULE3
    assign lamp_o.lamp = cur_r.lamps;
    assign fine_restore_o = cur_r.rest;
    assign fine_load_o = cur_r.load;

    // Divider codes go out already resolved, zero becoming one
    assign pll_o.out_div = eff_div(cur_r.rdiv); // see RULE7
    assign pll_o.loop_div = eff_div(cur_r.ndiv); // see RULE8
    assign pll_o.ref_hold = cur_r.hold; // see RULE9
    assign pll_o.reg_on = cur_r.ldo; // see RULE13
    assign pll_o.synth_on = cur_r.pll_en; // see RULE13
    assign pll_o.vco_auto = cur_r.vco_auto; // see RULE10
    assign pll_o.pd_delay = cur_r.pdel; // see RULE11
    assign pll_o.recal = cur_r.recal;
    assign pll_o.precharge_off = (cur_r.pre == PRE_DONE); // see RULE12

    //==================================================================
    // Assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Page field plus window carry, wrapping at 7 bits
    // Started only out of reset, so the first edge after release is not judged
    // against inputs that the reset branch never looked at
    property p_page_map;
        !rst_i |=> (mem_addr_o[9:0] == $past(crypto_addr_i[9:0])) &&
            (mem_addr_o[16:10] == 7'($past(cur_r.base) +
            {6'h00, $past(crypto_addr_i[10])}));
    endproperty
    a_page_map: assert property (p_page_map) // see RULE2
        else $error("Crypto address mapping wrong");

    property p_base_store;
        (wr_i && addr_i == OFF_MEM_BASE) |=> cur_r.base == $past(wdata_i[6:0]);
    endproperty
    a_base_store: assert property (p_base_store) // see RULE1
        else $error("Base page not stored");

    property p_trim;
        (wr_i && addr_i == OFF_LAMP) |=> lamp_o.trim == $past(wdata_i[9:6]);
    endproperty
    a_trim: assert property (p_trim) // see RULE3
        else $error("Lamp trim not taken from write");

    property p_lamp_a;
        1'b1 |=> lamp_o.lamp[0] == ($past(cur_r.lamp[ON_LSB]) &&
            ($past(cur_r.lamp[SRC_LSB]) ? $past(breath_i)
            : $past(pulse_channel_a_i)));
    endproperty
    a_lamp_a: assert property (p_lamp_a) // see RULE4
        else $error("Lamp a routing wrong");

    // Sleep entry is the single-cycle trigger of the hardware capture
    sequence s_capture;
        sleep_entry_i;
    endsequence
    sequence s_wake;
        wake_i;
    endsequence

    property p_capture;
        logic [9:0] v;
        (s_capture, v = radio_fine_counter_i) |=> cur_r.fine == v;
    endproperty
    a_capture: assert property (p_capture) // see RULE5
        else $error("Fine count not captured at sleep entry");

    property p_restore;
        s_wake |=> fine_load_o && fine_restore_o == $past(cur_r.fine)
            ##1 !fine_load_o || $past(wake_i);
    endproperty
    a_restore: assert property (p_restore) // see RULE5
        else $error("Fine count not restored at wake");

    // A write while asleep must land, otherwise the copy is frozen for software
    property p_sleep_write;
        (wr_i && addr_i == OFF_FINE && radio_asleep_i && !sleep_entry_i)
            |=> cur_r.fine == $past(wdata_i[9:0]);
    endproperty
    a_sleep_write: assert property (p_sleep_write) // see RULE6
        else $error("Asleep write did not reach fine copy");

    // An awake write must leave the copy alone
    property p_awake_write;
        (wr_i && addr_i == OFF_FINE && !radio_asleep_i && !sleep_entry_i)
            |=> $stable(cur_r.fine);
    endproperty
    a_awake_write: assert property (p_awake_write) // see RULE6
        else $error("Awake write changed fine copy");

    property p_div_nonzero;
        pll_o.out_div != 7'h00 && pll_o.loop_div != 7'h00;
    endproperty
    a_div_nonzero: assert property (p_div_nonzero) // see RULE7
        else $error("Divider code zero reached output");

    property p_reserved;
        rd_i |=> rdata_o[15] == 1'b0 || $past(addr_i) == OFF_PLL3;
    endproperty
    a_reserved: assert property (p_reserved) // see RULE14
        else $error("Reserved bit read nonzero");

    // Holes in the map read as all zeros
    property p_unmapped;
        (rd_i && reg_sel(addr_i) == SEL_NONE) |=> rdata_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) // see RULE14
        else $error("Unmapped read returned data");

    // Release is judged on the running counter against the programmed target

    sequence s_wait_over;
        cur_r.pre == PRE_WAIT && cur_r.pll_en && cur_r.ns >= target_ns;
    endsequence

    property p_release;
        s_wait_over |=> pll_o.precharge_off;
    endproperty
    a_release: assert property (p_release) // see RULE12
        else $error("Precharge not released after delay");

    property p_no_early;
        pll_o.precharge_off |-> cur_r.ns >= target_ns || $past(cur_r.sdel) != cur_r.sdel;
    endproperty
    a_no_early: assert property (p_no_early) // see RULE12
        else $error("Precharge released early");

    property p_drop;
        !cur_r.pll_en |=> !pll_o.precharge_off;
    endproperty
    a_drop: assert property (p_drop) // see RULE13
        else $error("Precharge stayed released with synth off");

endmodule : misc_system_config_regs

// ### verification/misc_system_config_regs_tb.sv
// Self-checking testbench for the system configuration register bank
`timescale 1ns/1ps
module testbench;
    import misc_cfg_pkg::*;

    //==================================================================
    // Stimulus and observed signals
    logic mclk_i, rst_i, wr_i, rd_i, breath_i, radio_asleep_i, sleep_entry_i, wake_i;
    logic pulse_channel_a_i, pulse_channel_b_i, pulse_channel_c_i;
    logic [31:0] addr_i;
    logic [15:0] wdata_i, rdata_o;
    logic [10:0] crypto_addr_i;
    logic [16:0] mem_addr_o;
    logic [9:0] radio_fine_counter_i, fine_restore_o;
    logic fine_load_o;
    lamp_out_s lamp_o;
    pll_ctrl_s pll_o;
    int n_mismatch = 0;
    int tests_run = 0;
    // Register table: offset, reset value, writable bits
    logic [31:0] offs [6] = '{OFF_MEM_BASE, OFF_LAMP, OFF_FINE, OFF_PLL1, OFF_PLL2, OFF_PLL3};
    logic [15:0] rst_v [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h2006, 16'h3c00};
    logic [15:0] msk [6] = '{16'h007f, 16'h03ff, 16'h03ff, 16'h7f07, 16'h707f, 16'hfc00};

    misc_system_config_regs i_misc_system_config_regs (.mclk_i(mclk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .crypto_addr_i(crypto_addr_i), .mem_addr_o(mem_addr_o),
        .pulse_channel_a_i(pulse_channel_a_i), .pulse_channel_b_i(pulse_channel_b_i),
        .pulse_channel_c_i(pulse_channel_c_i), .breath_i(breath_i), .lamp_o(lamp_o),
        .radio_fine_counter_i(radio_fine_counter_i), .radio_asleep_i(radio_asleep_i),
        .sleep_entry_i(sleep_entry_i), .wake_i(wake_i), .fine_restore_o(fine_restore_o),
        .fine_load_o(fine_load_o), .pll_o(pll_o));

    //==================================================================
    // Clock: 50 MHz
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    //==================================================================
    // Shared helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    // Strobe is dropped one edge later, so the next access starts a fresh edge
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, 32'(exp), 32'(rdata_o));
    endtask : rd_chk

    task automatic wrap_up;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    //==================================================================
    // Scenarios
    task automatic t_reset;
        pll_ctrl_s e;
        e = '{out_div: 7'h01, loop_div: 7'h06, pd_delay: 2'h2, default: '0};
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk("reset value", offs[i], rst_v[i]);
        chk("pll reset outputs", 32'(e), 32'(pll_o));
        chk("lamp reset outputs", 32'h0, 32'(lamp_o));
        chk("fine load at reset", 32'h0, 32'(fine_load_o));
    endtask : t_reset

    // Only the documented fields stick; reserved positions read zero
    task automatic t_regs;
        @(posedge mclk_i);
        radio_asleep_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(offs[i], 16'hffff);
            rd_chk("writable bits", offs[i], msk[i]);
            wr(offs[i], 16'h0000);
            rd_chk("cleared register", offs[i], 16'h0000);
        end
        wr(32'h50003316, 16'hffff);
        rd_chk("unmapped read", 32'h50003316, 16'h0000);
        tick(1);
        chk("read data after its cycle", 32'h0, 32'(rdata_o));
    endtask : t_regs

    task automatic map_chk(input logic [10:0] ca, input logic [16:0] exp);
        @(posedge mclk_i);
        crypto_addr_i <= ca;
        tick(2);
        chk("crypto memory address", 32'(exp), 32'(mem_addr_o));
    endtask : map_chk

    task automatic t_crypto;
        wr(OFF_MEM_BASE, 16'h0005);
        map_chk(11'h7ff, 17'h01bff);
        wr(OFF_MEM_BASE, 16'h007f);
        map_chk(11'h3ff, 17'h1ffff);
        map_chk(11'h400, 17'h00000);
        map_chk(11'h7ff, 17'h003ff);
    endtask : t_crypto

    task automatic t_lamps;
        logic [2:0] on, src, pls, exp;
        for (int k = 0; k < 8; k++) begin
            on = 3'(k);
            src = on ^ 3'b101;
            pls = on ^ 3'b011;
            @(posedge mclk_i);
            {pulse_channel_c_i, pulse_channel_b_i, pulse_channel_a_i} <= pls;
            breath_i <= on[0];
            wr(OFF_LAMP, {6'h00, 4'(k + 3), on, src});
            tick(2);
            for (int j = 0; j < 3; j++) exp[j] = on[j] & (src[j] ? on[0] : pls[j]);
            chk("lamp outputs", 32'(exp), 32'(lamp_o.lamp));
            chk("lamp current trim", 32'(k + 3), 32'(lamp_o.trim));
        end
    endtask : t_lamps

    task automatic t_fine;
        @(posedge mclk_i);
        radio_asleep_i <= 1'b0;
        radio_fine_counter_i <= 10'h155;
        wr(OFF_FINE, 16'h02aa);
        rd_chk("fine copy after awake write", OFF_FINE, 16'h0000);
        @(posedge mclk_i);
        sleep_entry_i <= 1'b1;
        @(posedge mclk_i);
        sleep_entry_i <= 1'b0;
        radio_asleep_i <= 1'b1;
        rd_chk("fine copy captured", OFF_FINE, 16'h0155);
        wr(OFF_FINE, 16'h0321);
        rd_chk("fine copy asleep write", OFF_FINE, 16'h0321);
        @(posedge mclk_i);
        wake_i <= 1'b1;
        @(posedge mclk_i);
        wake_i <= 1'b0;
        #1;
        chk("fine load pulse", 32'h1, 32'(fine_load_o));
        chk("fine restore value", 32'h321, 32'(fine_restore_o));
        tick(1);
        chk("fine load pulse end", 32'h0, 32'(fine_load_o));
    endtask : t_fine

    task automatic pll_step(input logic [31:0] a, input logic [15:0] d, input pll_ctrl_s e);
        wr(a, d);
        tick(2);
        chk("pll outputs", 32'(e), 32'(pll_o));
    endtask : pll_step

    task automatic t_pll;
        pll_step(OFF_PLL1, 16'h0506, '{out_div: 7'h05, loop_div: 7'h01, ref_hold: 1'b1,
            reg_on: 1'b1, default: '0});
        pll_step(OFF_PLL2, 16'h707f, '{out_div: 7'h05, loop_div: 7'h7f, ref_hold: 1'b1,
            reg_on: 1'b1, vco_auto: 1'b1, pd_delay: 2'h3, default: '0});
        pll_step(OFF_PLL1, 16'h7f00, '{out_div: 7'h7f, loop_div: 7'h7f, vco_auto: 1'b1,
            pd_delay: 2'h3, default: '0});
        pll_step(OFF_PLL2, 16'h1000, '{out_div: 7'h7f, loop_div: 7'h01, pd_delay: 2'h1,
            default: '0});
        pll_step(OFF_PLL1, 16'h0000, '{out_div: 7'h01, loop_div: 7'h01, pd_delay: 2'h1,
            default: '0});
        pll_step(OFF_PLL3, 16'h8000, '{out_div: 7'h01, loop_div: 7'h01, pd_delay: 2'h1,
            recal: 1'b1, default: '0});
    endtask : t_pll

    // Counts edges from the enabling write until the precharge resistors drop out
    task automatic t_prech(input logic [4:0] n, input int k);
        int i;
        wr(OFF_PLL3, {1'b0, n, 10'h000});
        wr(OFF_PLL1, 16'h0001);
        for (i = 1; i <= 100; i++) begin
            @(posedge mclk_i);
            #1;
            if (pll_o.precharge_off === 1'b1) break;
        end
        if (i > 100) begin
            n_mismatch++;
            wrap_up();
        end else begin
            chk("precharge release edge", 32'(k), 32'(i));
            chk("synth enable level", 32'h1, 32'(pll_o.synth_on));
            wr(OFF_PLL1, 16'h0000);
            tick(1);
            chk("precharge after disable", 32'h0, 32'(pll_o.precharge_off));
        end
    endtask : t_prech

    //==================================================================
    // Main sequence
    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 32'h0;
        wdata_i = 16'h0;
        crypto_addr_i = 11'h0;
        {pulse_channel_a_i, pulse_channel_b_i, pulse_channel_c_i, breath_i} = 4'h0;
        radio_fine_counter_i = 10'h0;
        {radio_asleep_i, sleep_entry_i, wake_i} = 3'h0;
        t_reset();
        t_regs();
        t_crypto();
        t_lamps();
        t_fine();
        t_pll();
        t_prech(5'h00, 2);
        t_prech(5'h01, 5);
        t_prech(5'h0f, 38);
        t_reset();
        wrap_up();
    end
endmodule : testbench
